/* File: pcg_defines.vh */
// constants for the power-up configuration and gpio control block
`ifndef PCG_DEFINES_VH
`define PCG_DEFINES_VH
`define PCG_CLK_HZ          10000000
`define PCG_STRAP_MS        50
`define PCG_STRAP_CYCLES    ((`PCG_CLK_HZ / 1000) * `PCG_STRAP_MS)
`define PCG_NUM_REGS        253
`define PCG_ADDR_W          8
// register offsets
`define PCG_ADDR_STOP01     8'h10
`define PCG_ADDR_STOP23     8'h11
`define PCG_ADDR_DIFF_EN    8'h12
`define PCG_ADDR_CMOS_EN    8'h13
`define PCG_ADDR_GPIO_CFG0  8'h20
`define PCG_ADDR_STATUS     8'hf0
`define PCG_ADDR_GPIO_IN    8'hf1
// reset values
`define PCG_RST_ZERO        8'h00
// gpio function codes
`define PCG_FN_NONE         7'h00
`define PCG_FN_STOP0_BASE   7'h44
`define PCG_FN_STOP1_BASE   7'h4c
`define PCG_FN_STOP23_BASE  7'h50
`define PCG_FN_DIFF_BASE    7'h60
`define PCG_FN_CMOS_BASE    7'h70
`define PCG_FN_IRQ          7'h7e
// strap field code and gpio count
`define PCG_MCLK_24M576     2'h3
`define PCG_NUM_GPIO        6
`endif

/* File: pcg_otp_rom.v */
// otp configuration image with load sequencer
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.vh"
module pcg_otp_rom #(
  parameter NUM_REGS = `PCG_NUM_REGS
) (
  input  wire       clock,
  input  wire       rstSync_n,
  input  wire       otpValid,
  output reg        loadWe,
  output reg  [7:0] loadAddr,
  output reg  [7:0] loadData,
  output reg        loadDone
);
  reg [7:0] readPtr;
  // arbitrary custom image; a programmed part would hold fuse contents here
  function [7:0] imageByte;
    input [7:0] a;
    begin
      imageByte = (a == `PCG_ADDR_DIFF_EN) ? 8'h00 : `PCG_RST_ZERO;
    end
  endfunction
  // address and data registered together so each byte lands at its own offset
  always @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      loadWe   <= 1'b0;
      loadAddr <= 8'h00;
      loadData <= 8'h00;
      loadDone <= 1'b0;
      readPtr  <= 8'h00;
    end else if (!loadDone) begin
      if (!otpValid || readPtr == NUM_REGS - 1) begin
        loadDone <= 1'b1;
      end
      loadWe   <= otpValid;
      loadAddr <= readPtr;
      loadData <= imageByte(readPtr);
      readPtr  <= readPtr + 8'h01;
    end else begin
      loadWe <= 1'b0;
    end
  end
endmodule // pcg_otp_rom
`default_nettype wire

/* File: pcg_gpio_map.v */
// decodes one gpio function code into its stop/enable/irq contribution
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.vh"
module pcg_gpio_map (
  input  wire        pinLevel,
  input  wire [6:0]  fnCode,
  output reg  [7:0]  stop01,
  output reg  [15:0] stop23,
  output reg  [7:0]  diffEn,
  output reg  [3:0]  cmosEn,
  output reg         irqSel
);
  reg [6:0] off;
  always @* begin
    off    = 7'h00;
    stop01 = 8'h00;
    stop23 = 16'h0000;
    diffEn = 8'h00;
    cmosEn = 4'h0;
    irqSel = 1'b0;
    if (fnCode >= `PCG_FN_STOP0_BASE && fnCode <= 7'h47) begin // RULE12
      off = fnCode - `PCG_FN_STOP0_BASE;
      stop01[off[1:0]] = pinLevel;
    end else if (fnCode >= `PCG_FN_STOP1_BASE && fnCode <= 7'h4f) begin // RULE12
      off = fnCode - `PCG_FN_STOP1_BASE;
      stop01[{1'b1, off[1:0]}] = pinLevel;
    end else if (fnCode >= `PCG_FN_STOP23_BASE && fnCode <= 7'h5f) begin // RULE13
      off = fnCode - `PCG_FN_STOP23_BASE;
      stop23[off[3:0]] = pinLevel;
    end else if (fnCode >= `PCG_FN_DIFF_BASE && fnCode <= 7'h6e && !fnCode[0]) begin // RULE14
      off = fnCode - `PCG_FN_DIFF_BASE;
      diffEn[off[3:1]] = pinLevel;
    end else if (fnCode >= `PCG_FN_CMOS_BASE && fnCode <= 7'h76 && !fnCode[0]) begin // RULE15
      off = fnCode - `PCG_FN_CMOS_BASE;
      cmosEn[off[2:1]] = pinLevel;
    end else if (fnCode == `PCG_FN_IRQ) begin // RULE16
      irqSel = 1'b1;
    end
    // code 0x00 and unlisted codes leave the pin an unassigned input
  end // RULE11 RULE23
endmodule // pcg_gpio_map
`default_nettype wire

/* File: pcg_config_ctrl.v */
// power-up reset, strap capture, configuration store and gpio control mapping
// Operation
// (RULE1) board holds reset low 2 ms minimum
// (RULE2) defaults apply after reset unless otp
// (RULE3) board holds straps 50 ms after release
// (RULE4) straps become plain gpio after window
// (RULE5) all outputs disabled after reset
// (RULE6) gpio2 high enables differential output 0
// (RULE7) store holds 253 byte registers
// (RULE8) custom part loads store from otp; the loader starts at reset and its bytes reach store only while in ST_LOAD
// (RULE9) host writes lost on reset
// (RULE10) bits 6:0 select gpio function
// (RULE11) code 0x00 leaves pin plain input
// (RULE12) synth 0/1 stop codes ORed in
// (RULE13) synth 2/3 stop codes ORed in
// (RULE14) even 0x60-0x6e enable differential outputs
// (RULE15) even 0x70-0x76 enable cmos outputs
// (RULE16) gpio may carry host interrupt output
// (RULE17) synthesizer frequency ranges in 1 kHz steps
// (RULE18) post divider enable, ratios, skew
// (RULE19) driver enable, mode, slew settable
// (RULE20) strap code 3 selects 24.576 MHz
// (RULE21) gpio3 strap selects spi or i2c
// (RULE22) straps captured once at window end
// (RULE23) unlisted codes act like default
//
// Design decisions made here: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pcg_defines.vh"
module pcg_config_ctrl #(
  parameter STRAP_CYCLES = `PCG_STRAP_CYCLES,
  parameter NUM_GPIO     = `PCG_NUM_GPIO,
  parameter NUM_REGS     = `PCG_NUM_REGS
) (
  input  wire                clock,
  input  wire                rst_n,
  input  wire [NUM_GPIO-1:0] gpioIn,
  input  wire                otpValid,
  input  wire                statusEvent,
  input  wire [7:0]          regAddr,
  input  wire [7:0]          regWdata,
  input  wire                regWr,
  input  wire                regRd,
  output reg  [7:0]          regRdata,
  output reg                 configReady,
  output reg                 strapDone,
  output reg  [1:0]          mclkSel,
  output reg                 mclkValid,
  output reg                 hostIsI2c,
  output reg  [1:0]          strapAux,
  output reg  [7:0]          stop01Out,
  output reg  [15:0]         stop23Out,
  output reg  [7:0]          diffEnOut,
  output reg  [3:0]          cmosEnOut,
  output reg  [NUM_GPIO-1:0] gpioOut,
  output reg  [NUM_GPIO-1:0] gpioOe
);
  localparam ST_STRAP = 3'b001;
  localparam ST_LOAD  = 3'b010;
  localparam ST_RUN   = 3'b100;

  reg  [1:0]          rstPipe_reg;
  wire                rstSync_n;
  reg  [NUM_GPIO-1:0] gpioMeta_reg;
  reg  [NUM_GPIO-1:0] gpioSync_reg;
  reg  [2:0]          state_reg;
  reg  [2:0]          state_next;
  reg  [31:0]         strapCnt_reg;
  reg  [7:0]          store [0:255];
  reg                 irqPend_reg;
  wire                loadWe;
  wire [7:0]          loadAddr;
  wire [7:0]          loadData;
  wire                loadDone;
  wire [7:0]          mapStop01 [0:NUM_GPIO-1];
  wire [15:0]         mapStop23 [0:NUM_GPIO-1];
  wire [7:0]          mapDiff   [0:NUM_GPIO-1];
  wire [3:0]          mapCmos   [0:NUM_GPIO-1];
  wire [NUM_GPIO-1:0] mapIrq;
  reg  [7:0]          pinStop01;
  reg  [15:0]         pinStop23;
  reg  [7:0]          pinDiff;
  reg  [3:0]          pinCmos;
  integer k;

  function automatic isStoreAddr;
    input [7:0] a;
    begin
      isStoreAddr = (a < NUM_REGS);
    end
  endfunction

  // reset released through two flops
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe_reg <= 2'b00;
    end else begin
      rstPipe_reg <= {rstPipe_reg[0], 1'b1};
    end
  end
  assign rstSync_n = rstPipe_reg[1];

  // pins are asynchronous, two flops before use
  always @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      gpioMeta_reg <= {NUM_GPIO{1'b0}};
      gpioSync_reg <= {NUM_GPIO{1'b0}};
    end else begin
      gpioMeta_reg <= gpioIn;
      gpioSync_reg <= gpioMeta_reg;
    end
  end

  pcg_otp_rom #(
    .NUM_REGS  (NUM_REGS)
  ) otpLoader (
    .clock     (clock),
    .rstSync_n (rstSync_n),
    .otpValid  (otpValid),
    .loadWe    (loadWe),
    .loadAddr  (loadAddr),
    .loadData  (loadData),
    .loadDone  (loadDone)
  );

  always @* begin
    case (state_reg)
      ST_STRAP: state_next = (strapCnt_reg >= STRAP_CYCLES - 1) ? ST_LOAD : ST_STRAP; // RULE4
      ST_LOAD:  state_next = loadDone ? ST_RUN : ST_LOAD;
      ST_RUN:   state_next = ST_RUN;
      default:  state_next = ST_STRAP;
    endcase
  end

  always @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_reg    <= ST_STRAP;
      strapCnt_reg <= 32'h00000000;
      strapDone    <= 1'b0;
      mclkSel      <= 2'h0;
      mclkValid    <= 1'b0;
      hostIsI2c    <= 1'b0;
      strapAux     <= 2'h0;
      configReady  <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_STRAP) begin
        strapCnt_reg <= strapCnt_reg + 32'h00000001;
      end
      if (state_reg == ST_STRAP && state_next == ST_LOAD) begin // RULE22
        strapDone <= 1'b1;
        mclkSel   <= gpioSync_reg[1:0];
        mclkValid <= (gpioSync_reg[1:0] == `PCG_MCLK_24M576); // RULE20
        hostIsI2c <= gpioSync_reg[3]; // RULE21
        strapAux  <= gpioSync_reg[5:4];
      end
      configReady <= (state_reg == ST_RUN);
    end
  end

  // store: cleared at reset, otp overlays, then host writes
  always @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      for (k = 0; k < 256; k = k + 1) begin
        store[k] <= `PCG_RST_ZERO; // RULE2 RULE5 RULE9
      end
    end else if (loadWe && state_reg == ST_LOAD) begin
      store[loadAddr] <= loadData; // RULE8
    end else if (regWr && state_reg == ST_RUN && isStoreAddr(regAddr)) begin
      store[regAddr] <= regWdata; // RULE7 RULE17 RULE18 RULE19
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_GPIO; g = g + 1) begin : gpioFn
      pcg_gpio_map mapper (
        .pinLevel (gpioSync_reg[g] & strapDone), // RULE4
        .fnCode   (store[`PCG_ADDR_GPIO_CFG0 + g][6:0]), // RULE10
        .stop01   (mapStop01[g]),
        .stop23   (mapStop23[g]),
        .diffEn   (mapDiff[g]),
        .cmosEn   (mapCmos[g]),
        .irqSel   (mapIrq[g])
      );
    end
  endgenerate

  always @* begin
    pinStop01 = 8'h00;
    pinStop23 = 16'h0000;
    pinDiff   = 8'h00;
    pinCmos   = 4'h0;
    for (k = 0; k < NUM_GPIO; k = k + 1) begin
      pinStop01 = pinStop01 | mapStop01[k];
      pinStop23 = pinStop23 | mapStop23[k];
      pinDiff   = pinDiff | mapDiff[k];
      pinCmos   = pinCmos | mapCmos[k];
    end
    // gpio2 bring-up path, works with no software
    pinDiff[0] = pinDiff[0] | (gpioSync_reg[2] & strapDone); // RULE6
  end

  always @(posedge clock or negedge rstSync_n) begin
    if (!rstSync_n) begin
      stop01Out   <= 8'h00;
      stop23Out   <= 16'h0000;
      diffEnOut   <= 8'h00;
      cmosEnOut   <= 4'h0;
      irqPend_reg <= 1'b0;
      gpioOut     <= {NUM_GPIO{1'b0}};
      gpioOe      <= {NUM_GPIO{1'b0}};
      regRdata    <= 8'h00;
    end else begin
      stop01Out <= store[`PCG_ADDR_STOP01] | pinStop01; // RULE12
      stop23Out <= {store[`PCG_ADDR_STOP23], store[`PCG_ADDR_STOP23]} | pinStop23; // RULE13
      diffEnOut <= (state_reg == ST_RUN) ? (store[`PCG_ADDR_DIFF_EN] | pinDiff) : 8'h00; // RULE14
      cmosEnOut <= (state_reg == ST_RUN) ? (store[`PCG_ADDR_CMOS_EN][3:0] | pinCmos) : 4'h0; // RULE15
      // set beats clear: a status event in the read cycle stays pending
      if (statusEvent) begin
        irqPend_reg <= 1'b1;
      end else if (regRd && regAddr == `PCG_ADDR_STATUS) begin
        irqPend_reg <= 1'b0;
      end
      gpioOut <= {NUM_GPIO{irqPend_reg}} & mapIrq; // RULE16
      gpioOe  <= mapIrq & {NUM_GPIO{strapDone}};
      if (regRd) begin
        if (regAddr == `PCG_ADDR_STATUS) begin
          regRdata <= {3'h0, irqPend_reg, hostIsI2c, mclkValid, strapDone, configReady};
        end else if (regAddr == `PCG_ADDR_GPIO_IN) begin
          regRdata <= {{(8 - NUM_GPIO){1'b0}}, gpioSync_reg};
        end else if (isStoreAddr(regAddr)) begin
          regRdata <= store[regAddr];
        end else begin
          regRdata <= 8'h00;
        end
      end else begin
        regRdata <= 8'h00;
      end
    end
  end
endmodule // pcg_config_ctrl
`default_nettype wire

/* File: pcg_config_chk.sv */
// port assertions for the configuration controller
`timescale 1ns/1ps
`default_nettype none
module pcg_config_chk #(
  parameter NUM_GPIO = 6
) (
  input wire logic                clock,
  input wire logic                rst_n,
  input wire logic                regRd,
  input wire logic [7:0]          regRdata,
  input wire logic                configReady,
  input wire logic                strapDone,
  input wire logic [1:0]          mclkSel,
  input wire logic                mclkValid,
  input wire logic                hostIsI2c,
  input wire logic [1:0]          strapAux,
  input wire logic [7:0]          diffEnOut,
  input wire logic [3:0]          cmosEnOut,
  input wire logic [NUM_GPIO-1:0] gpioOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_outs_off_early: assert property (!configReady |-> diffEnOut == 8'h00 && cmosEnOut == 4'h0)
    else $error("output enabled before ready");
  // load may take a full image, so allow up to 300 cycles
  a_ready_after_wnd: assert property ($rose(strapDone) |-> !configReady ##[1:300] configReady)
    else $error("ready not after strap window");
  a_ready_holds: assert property (configReady |-> strapDone ##1 configReady)
    else $error("ready dropped");
  a_strap_stays: assert property (strapDone |=> strapDone)
    else $error("strap done dropped");
  a_strap_frozen: assert property (strapDone && $past(strapDone) |->
    $stable({mclkSel, hostIsI2c, strapAux}))
    else $error("captured straps changed");
  a_mclk_code: assert property (strapDone |-> mclkValid == (mclkSel == 2'h3))
    else $error("master clock valid wrong");
  a_rdata_idle: assert property (!$past(regRd) |-> regRdata == 8'h00)
    else $error("read data outside read slot");
  a_oe_in_window: assert property (!strapDone |-> gpioOe == '0)
    else $error("pin driven during strap window");
endmodule // pcg_config_chk
bind pcg_config_ctrl pcg_config_chk #(.NUM_GPIO(NUM_GPIO)) chk (
  .clock(clock), .rst_n(rst_n), .regRd(regRd), .regRdata(regRdata),
  .configReady(configReady), .strapDone(strapDone), .mclkSel(mclkSel),
  .mclkValid(mclkValid), .hostIsI2c(hostIsI2c), .strapAux(strapAux),
  .diffEnOut(diffEnOut), .cmosEnOut(cmosEnOut), .gpioOe(gpioOe)
);
`default_nettype wire

/* File: pcg_board.sv */
// board side: reset pulse and strap drivers
`timescale 1ns/1ps
`default_nettype none
module pcg_board #(
  parameter int RST_CYC  = 4,
  parameter int HOLD_CYC = 30
) (
  input  wire logic       clock,
  input  wire logic       resetReq,
  input  wire logic [5:0] strap,
  input  wire logic [5:0] pins,
  input  wire logic [5:0] gpioOut,
  input  wire logic [5:0] gpioOe,
  output var  logic       rst_n,
  output wire logic [5:0] gpioIn
);
  int              cnt = 0;
  wire logic [5:0] drive;
  initial rst_n = 1'b0;
  // reset time scaled down, the real minimum would dominate the run
  always @(posedge clock) begin
    if (resetReq) begin
      rst_n <= 1'b0;
      cnt   <= 0;
    end else if (cnt < RST_CYC + HOLD_CYC) begin
      cnt <= cnt + 1;
      if (cnt == RST_CYC - 1) rst_n <= 1'b1;
    end
  end
  assign drive  = (cnt < RST_CYC + HOLD_CYC) ? strap : pins;
  assign gpioIn = (gpioOe & gpioOut) | (~gpioOe & drive);
endmodule // pcg_board
`default_nettype wire

/* File: pcg_config_ctrl_bench.sv */
// self-checking bench for the configuration controller
`timescale 1ns/1ps
`default_nettype none
module pcg_config_ctrl_bench;
  logic        clock, resetReq, otpValid, regWr, regRd, rst_n, statusEvent;
  logic        configReady, strapDone, mclkValid, hostIsI2c;
  logic [7:0]  regAddr, regWdata, regRdata, rdVal, r, stop01Out, diffEnOut;
  logic [15:0] stop23Out;
  logic [3:0]  cmosEnOut;
  logic [5:0]  strap, pins, gpioIn, gpioOut, gpioOe;
  logic [1:0]  mclkSel, strapAux;
  int          err_count, num_checks, seed, i;
  pcg_board brd (.clock(clock), .resetReq(resetReq), .strap(strap), .pins(pins),
    .gpioOut(gpioOut), .gpioOe(gpioOe), .rst_n(rst_n), .gpioIn(gpioIn));
  pcg_config_ctrl #(.STRAP_CYCLES(20)) uut (.clock(clock), .rst_n(rst_n), .gpioIn(gpioIn),
    .otpValid(otpValid), .statusEvent(statusEvent), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .configReady(configReady),
    .strapDone(strapDone), .mclkSel(mclkSel), .mclkValid(mclkValid), .hostIsI2c(hostIsI2c),
    .strapAux(strapAux), .stop01Out(stop01Out), .stop23Out(stop23Out),
    .diffEnOut(diffEnOut), .cmosEnOut(cmosEnOut), .gpioOut(gpioOut), .gpioOe(gpioOe));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input logic [35:0] got, input logic [35:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clock);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRd <= 1'b0;
    #1 rdVal = regRdata;
  endtask
  task automatic boot(input logic [5:0] s, input logic otp);
    int n;
    @(posedge clock);
    strap    <= s;
    otpValid <= otp;
    resetReq <= 1'b1;
    @(posedge clock);
    resetReq <= 1'b0;
    @(posedge clock);
    n = 0;
    while (configReady !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    if (n >= 400) begin
      err_count++;
      $display("unexpected at %0t: ready never came", $time);
      give_verdict;
    end
  endtask
  // bit order {stop01, stop23, diffEn, cmosEn}; unlisted codes give nothing
  function automatic logic [35:0] fn_exp(input logic [6:0] c);
    logic [35:0] e;
    int          k;
    e = '0;
    k = int'(c);
    if (k >= 'h44 && k <= 'h47) e[28 + k - 'h44] = 1'b1;
    if (k >= 'h4c && k <= 'h4f) e[32 + k - 'h4c] = 1'b1;
    if (k >= 'h50 && k <= 'h5f) e[12 + k - 'h50] = 1'b1;
    if (k >= 'h60 && k <= 'h6e && !c[0]) e[4 + (k - 'h60) / 2] = 1'b1;
    if (k >= 'h70 && k <= 'h76 && !c[0]) e[(k - 'h70) / 2] = 1'b1;
    return e;
  endfunction
  initial begin
    seed = 32'hcec5;
    err_count = 0;
    num_checks = 0;
    {resetReq, otpValid, regWr, regRd, statusEvent, regAddr, regWdata, strap, pins} = '0;
    for (i = 0; i < 4; i++) begin
      // gpio2 is not a strap; keep it low so it cannot enable an output early
      r = ((i == 0) ? 8'h0b : (i == 1) ? 8'h34 : 8'($random(seed))) & 8'h3b;
      boot(r[5:0], i[0]);
      pins <= ~r[5:0] & 6'h3b;
      settle(5);
      check({mclkSel, mclkValid, hostIsI2c, strapAux},
        {r[1:0], r[1:0] == 2'h3, r[3], r[5:4]}, "strap capture");
      check({diffEnOut, cmosEnOut}, '0, "outputs enabled");
      rd(8'h12);
      check(rdVal, '0, "volatile reg kept");
      wr(8'h12, r);
      wr(8'hfe, 8'h5a);
      settle(2);
      check(diffEnOut, r, "enable write");
      rd(8'h12);
      check(rdVal, r, "readback");
      rd(8'hfe);
      check(rdVal, '0, "unmapped read");
      $display("test strap boot %0d done", i);
    end
    wr(8'h12, 8'h00);
    pins <= 6'h10;
    for (i = 0; i < 128; i++) begin
      r = 8'($random(seed));
      wr(8'h24, {r[0], i[6:0]});
      settle(5);
      check({stop01Out, stop23Out, diffEnOut, cmosEnOut}, fn_exp(i[6:0]),
        "pin function");
    end
    $display("test function sweep done");
    r = 8'($random(seed)) & 8'hfe;
    wr(8'h24, 8'h60);
    wr(8'h12, r);
    settle(5);
    check(diffEnOut, r | 8'h01, "pin or register");
    pins <= 6'h04;
    wr(8'h24, 8'h00);
    settle(5);
    check(diffEnOut, r | 8'h01, "gpio2 enable");
    pins <= 6'h00;
    settle(5);
    check(diffEnOut, r, "pin released");
    $display("test pin enable done");
    wr(8'h24, 8'h7e);
    @(posedge clock);
    statusEvent <= 1'b1;
    @(posedge clock);
    statusEvent <= 1'b0;
    settle(3);
    check({gpioOe[4], gpioOut[4]}, 2'b11, "irq pin");
    rd(8'hf0);
    check(rdVal[4], 1'b1, "irq status");
    settle(3);
    check({gpioOe[4], gpioOut[4]}, 2'b10, "irq cleared");
    $display("test irq pin done");
    give_verdict;
  end
endmodule // pcg_config_ctrl_bench
`default_nettype wire
